//--- urd_host.sv
// Host processor model that drives the parallel register port of the bank.
`timescale 1ns/10ps
module urd_host (
   // Clock and read data from the bank.
   input wire logic i_ref_clk,
   input wire logic [7:0] i_rd_data,
   // Parallel host strobes, select lines and write data.
   output logic [2:0] o_register_select_lines,
   output logic o_rd,
   output logic o_wr,
   output logic [7:0] o_wr_data
);
   // The port starts idle with both strobes low.
   initial begin
      o_register_select_lines = 3'h0;
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_wr_data = 8'h00;
   end

   // One access, driven at the next falling edge and held across the taking edge.
   // The leading wait lets a rising edge pass with the strobes low, so a strobe
   // released by the previous access is never raised again in the same time step.
   task automatic access(input logic [2:0] addr, input logic wr_en, input logic [7:0] data,
                         output logic [7:0] rdata);
      @(negedge i_ref_clk);
      o_register_select_lines = addr;
      o_wr_data = data;
      o_rd = ~wr_en;
      o_wr = wr_en;
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      o_rd = 1'b0;
      o_wr = 1'b0;
      rdata = i_rd_data;
      // Released lines flip so that no stale value is mistaken for a request.
      o_register_select_lines = ~addr;
      o_wr_data = ~data;
   endtask

   // Write at one edge and read the same place at the very next edge.
   task automatic write_read(input logic [2:0] addr, input logic [7:0] data,
                             output logic [7:0] rdata);
      @(negedge i_ref_clk);
      o_register_select_lines = addr;
      o_wr_data = data;
      o_wr = 1'b1;
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      o_wr = 1'b0;
      o_rd = 1'b1;
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      o_rd = 1'b0;
      rdata = i_rd_data;
      o_register_select_lines = ~addr;
      o_wr_data = ~data;
   endtask
endmodule

//--- urd_pkg.sv
// Package with offsets, field positions and reset values of the UART register bank.
package urd_pkg;
   // Register select codes.
   localparam logic [2:0] URD_A_HOLD = 3'h0;
   localparam logic [2:0] URD_A_IER = 3'h1;
   localparam logic [2:0] URD_A_ISR = 3'h2;
   localparam logic [2:0] URD_A_LCR = 3'h3;
   localparam logic [2:0] URD_A_MCR = 3'h4;
   localparam logic [2:0] URD_A_LSR = 3'h5;
   localparam logic [2:0] URD_A_MSR = 3'h6;
   localparam logic [2:0] URD_A_SPR = 3'h7;
   // Line control value that opens the enhanced register set.
   localparam logic [7:0] URD_ENH_KEY = 8'hBF;
   // Field positions.
   localparam int URD_LCR_DLAB = 7;
   localparam int URD_EFR_SHADE_EN = 4;
   localparam int URD_EFR_AUTO_RTS = 6;
   localparam int URD_EFR_AUTO_CTS = 7;
   localparam int URD_FEATURE_CONTROL_SWAP = 6;
   localparam int URD_FEATURE_CONTROL_TXMODE = 7;
   localparam int URD_FCR_FIFO_EN = 0;
   localparam int URD_FCR_RX_RST = 1;
   localparam int URD_FCR_TX_RST = 2;
   localparam int URD_MCR_DTR = 0;
   localparam int URD_MCR_RTS = 1;
   localparam int URD_MCR_OUT2 = 3;
   localparam int URD_MCR_LOOP = 4;
   // Bits that only act while the shade enable is set.
   localparam logic [7:0] URD_IER_SHADE = 8'hF0;
   localparam logic [7:0] URD_ISR_SHADE = 8'h30;
   localparam logic [7:0] URD_FCR_SHADE = 8'h30;
   localparam logic [7:0] URD_MCR_SHADE = 8'hE0;
   // Bits that exist in each register; others are stored as zero.
   localparam logic [7:0] URD_FCR_KEEP = 8'hF9;
   localparam logic [7:0] URD_MCR_KEEP = 8'hFB;
   localparam logic [7:0] URD_FEATURE_CONTROL_KEEP = 8'hF3;
   localparam logic [7:0] URD_EFR_KEEP = 8'hD0;
   localparam logic [7:0] URD_IER_KEEP = 8'hCF;
   localparam logic [7:0] URD_ISR_SRC = 8'h3F;
   // Reset values.
   localparam logic [7:0] URD_RST_BYTE = 8'h00;
   localparam logic [7:0] URD_ZERO = 8'h00;
   // Arbitrary identification values, replaceable per product.
   localparam logic [7:0] URD_REV_CODE = 8'h01;
   localparam logic [7:0] URD_ID_CODE = 8'h5A;
endpackage

//--- urd_regs.sv
// Host register bank and address decoder of the enhanced UART.
//
// Notes on behaviour
// - Three select lines pick the register.
// - Serial host mode blocks the parallel lines.
// - Microcontroller locked out in parallel host mode.
// - Address zero: receive read, transmit write.
// - Divisor enable maps divisor bytes at 0/1.
// - Zero divisor reads give revision and identity.
// - Interrupt enable register at address one.
// - Address two reads interrupt status.
// - Address two writes FIFO control.
// - Line control always at address three.
// - Modem control at address four drives pins.
// - Address five reads line status.
// - Address six reads modem status.
// - Scratch pad at seven without swap.
// - Swap: writes at seven load mode select.
// - Swap: reads at seven give FIFO level.
// - Enhanced set: trigger write, count read.
// - Enhanced set: feature control at one.
// - Enhanced set: function register at two.
// - Shaded bits act only with enable.
// - Function bits 7/6 enable auto flow.
`timescale 1ns/10ps
module urd_regs
   import urd_pkg::*;
#(
   parameter logic [7:0] P_REV_CODE = URD_REV_CODE,
   parameter logic [7:0] P_ID_CODE = URD_ID_CODE
) (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Host mode: high for parallel host, low for serial host.
   input wire logic i_parallel_mode,
   // Parallel host port.
   input wire logic [2:0] i_register_select_lines,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [7:0] i_wr_data,
   // Embedded microcontroller port.
   input wire logic [2:0] i_mcu_addr,
   input wire logic i_mcu_rd,
   input wire logic i_mcu_wr,
   input wire logic [7:0] i_mcu_wr_data,
   // Read data to whichever port owns the bank.
   output logic [7:0] o_rd_data,
   // Datapath status.
   input wire logic [7:0] i_rx_holding,
   input wire logic [7:0] i_interrupt_status,
   input wire logic [7:0] i_line_status,
   input wire logic [7:0] i_modem_status,
   input wire logic [7:0] i_rx_fifo_level,
   input wire logic [7:0] i_tx_fifo_level,
   // Datapath strobes.
   output logic o_tx_holding_load,
   output logic [7:0] o_tx_holding,
   output logic o_rx_holding_pop,
   output logic o_line_status_read,
   output logic o_modem_status_read,
   output logic o_rx_fifo_reset,
   output logic o_tx_fifo_reset,
   output logic o_trigger_load,
   // Configuration.
   output logic [15:0] o_baud_divisor,
   output logic [7:0] o_interrupt_enable,
   output logic [7:0] o_fifo_control,
   output logic [7:0] o_line_control,
   output logic [7:0] o_modem_control,
   output logic [7:0] o_scratch_pad,
   output logic [7:0] o_enhanced_mode_select,
   output logic [7:0] o_feature_control,
   output logic [7:0] o_enhanced_function,
   output logic [7:0] o_fifo_trigger_level,
   // Modem pins and flow control enables.
   output logic o_data_terminal_ready,
   output logic o_request_to_send,
   output logic o_interrupt_output_enable,
   output logic o_loopback,
   output logic o_auto_cts_en,
   output logic o_auto_rts_en
);

   logic [7:0] dll_ff, nxt_dll;
   logic [7:0] dlm_ff, nxt_dlm;
   logic [7:0] ier_ff, nxt_ier;
   logic [7:0] fcr_ff, nxt_fcr;
   logic [7:0] lcr_ff, nxt_lcr;
   logic [7:0] mcr_ff, nxt_mcr;
   logic [7:0] spr_ff, nxt_spr;
   logic [7:0] enhanced_mode_select_ff, nxt_enhanced_mode_select;
   logic [7:0] feature_control_ff, nxt_feature_control;
   logic [7:0] efr_ff, nxt_efr;
   logic [7:0] trg_ff, nxt_trg;
   logic [7:0] thr_ff, nxt_thr;
   logic [7:0] rdata_ff, nxt_rdata;
   logic thr_ld_ff, nxt_thr_ld;
   logic pop_ff, nxt_pop;
   logic lsr_rd_ff, nxt_lsr_rd;
   logic msr_rd_ff, nxt_msr_rd;
   logic rxrst_ff, nxt_rxrst;
   logic txrst_ff, nxt_txrst;
   logic trg_ld_ff, nxt_trg_ld;
   logic [2:0] addr;
   logic rd, wr;
   logic [7:0] wdata;
   logic enh, dlab, shade, div_zero;
   logic [7:0] shade_ier, shade_isr, shade_fcr, shade_mcr, fifo_level;

   // Owner selection: the parallel host owns the bank in parallel mode, the
   // microcontroller in serial mode, so the two can never collide.
   always_comb begin
      if (i_parallel_mode) begin
         addr = i_register_select_lines;
         rd = i_rd;
         wr = i_wr;
         wdata = i_wr_data;
      end else begin
         addr = i_mcu_addr;
         rd = i_mcu_rd;
         wr = i_mcu_wr;
         wdata = i_mcu_wr_data;
      end
   end

   // Decode qualifiers and masks for shaded bits.
   assign enh = (lcr_ff == URD_ENH_KEY);
   assign dlab = lcr_ff[URD_LCR_DLAB];
   assign shade = efr_ff[URD_EFR_SHADE_EN];
   assign div_zero = (dll_ff == URD_ZERO) && (dlm_ff == URD_ZERO);
   assign shade_ier = shade ? 8'hFF : ~URD_IER_SHADE;
   assign shade_isr = shade ? 8'hFF : ~URD_ISR_SHADE;
   assign shade_fcr = shade ? 8'hFF : ~URD_FCR_SHADE;
   assign shade_mcr = shade ? 8'hFF : ~URD_MCR_SHADE;
   assign fifo_level = feature_control_ff[URD_FEATURE_CONTROL_TXMODE] ? i_tx_fifo_level : i_rx_fifo_level;

   // Next values of the writable registers and the write strobes from the decoded access.
   always_comb begin
      nxt_dll = dll_ff;
      nxt_dlm = dlm_ff;
      nxt_ier = ier_ff;
      nxt_fcr = fcr_ff;
      nxt_lcr = lcr_ff;
      nxt_mcr = mcr_ff;
      nxt_spr = spr_ff;
      nxt_enhanced_mode_select = enhanced_mode_select_ff;
      nxt_feature_control = feature_control_ff;
      nxt_efr = efr_ff;
      nxt_trg = trg_ff;
      nxt_thr = thr_ff;
      nxt_thr_ld = 1'b0;
      nxt_trg_ld = 1'b0;
      nxt_rxrst = 1'b0;
      nxt_txrst = 1'b0;
      if (wr) begin
         unique case (addr)
            URD_A_HOLD: begin
               if (enh) begin
                  nxt_trg = wdata;
                  nxt_trg_ld = 1'b1;
               end else if (dlab) begin
                  nxt_dll = wdata;
               end else begin
                  nxt_thr = wdata;
                  nxt_thr_ld = 1'b1;
               end
            end
            URD_A_IER: begin
               if (enh) begin
                  nxt_feature_control = wdata & URD_FEATURE_CONTROL_KEEP;
               end else if (dlab) begin
                  nxt_dlm = wdata;
               end else begin
                  nxt_ier = wdata & URD_IER_KEEP;
               end
            end
            URD_A_ISR: begin
               if (enh) begin
                  nxt_efr = wdata & URD_EFR_KEEP;
               end else begin
                  nxt_fcr = wdata & URD_FCR_KEEP;
                  nxt_rxrst = wdata[URD_FCR_RX_RST];
                  nxt_txrst = wdata[URD_FCR_TX_RST];
               end
            end
            URD_A_LCR: nxt_lcr = wdata;
            URD_A_MCR: begin
               if (!enh) begin
                  nxt_mcr = wdata & URD_MCR_KEEP;
               end
            end
            URD_A_LSR, URD_A_MSR: begin
               // Read-only locations; writes are dropped.
            end
            URD_A_SPR: begin
               if (!enh && feature_control_ff[URD_FEATURE_CONTROL_SWAP]) begin
                  nxt_enhanced_mode_select = wdata;
               end else if (!enh) begin
                  nxt_spr = wdata;
               end
            end
         endcase
      end
   end

   // Read data mux; captured into a register on the read strobe.
   always_comb begin
      nxt_rdata = rdata_ff;
      nxt_pop = 1'b0;
      nxt_lsr_rd = 1'b0;
      nxt_msr_rd = 1'b0;
      if (rd) begin
         nxt_rdata = URD_ZERO;
         unique case (addr)
            URD_A_HOLD: begin
               if (enh) begin
                  nxt_rdata = fifo_level;
               end else if (dlab) begin
                  nxt_rdata = div_zero ? P_REV_CODE : dll_ff;
               end else begin
                  nxt_rdata = i_rx_holding;
                  nxt_pop = 1'b1;
               end
            end
            URD_A_IER: begin
               if (enh) begin
                  nxt_rdata = feature_control_ff;
               end else if (dlab) begin
                  nxt_rdata = div_zero ? P_ID_CODE : dlm_ff;
               end else begin
                  nxt_rdata = ier_ff & shade_ier;
               end
            end
            URD_A_ISR: begin
               if (enh) begin
                  nxt_rdata = efr_ff;
               end else begin
                  nxt_rdata = (i_interrupt_status & URD_ISR_SRC & shade_isr)
                     | {{2{fcr_ff[URD_FCR_FIFO_EN]}}, 6'h00};
               end
            end
            URD_A_LCR: nxt_rdata = lcr_ff;
            URD_A_MCR: begin
               if (!enh) begin
                  nxt_rdata = mcr_ff & shade_mcr;
               end
            end
            URD_A_LSR: begin
               if (!enh) begin
                  nxt_rdata = i_line_status;
                  nxt_lsr_rd = 1'b1;
               end
            end
            URD_A_MSR: begin
               if (!enh) begin
                  nxt_rdata = i_modem_status;
                  nxt_msr_rd = 1'b1;
               end
            end
            URD_A_SPR: begin
               if (!enh) begin
                  nxt_rdata = feature_control_ff[URD_FEATURE_CONTROL_SWAP] ? fifo_level : spr_ff;
               end
            end
         endcase
      end
   end

   // Register stage for all state of the bank.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         dll_ff <= URD_RST_BYTE;
         dlm_ff <= URD_RST_BYTE;
         ier_ff <= URD_RST_BYTE;
         fcr_ff <= URD_RST_BYTE;
         lcr_ff <= URD_RST_BYTE;
         mcr_ff <= URD_RST_BYTE;
         spr_ff <= URD_RST_BYTE;
         enhanced_mode_select_ff <= URD_RST_BYTE;
         feature_control_ff <= URD_RST_BYTE;
         efr_ff <= URD_RST_BYTE;
         trg_ff <= URD_RST_BYTE;
         thr_ff <= URD_RST_BYTE;
         rdata_ff <= URD_RST_BYTE;
         thr_ld_ff <= 1'b0;
         pop_ff <= 1'b0;
         lsr_rd_ff <= 1'b0;
         msr_rd_ff <= 1'b0;
         rxrst_ff <= 1'b0;
         txrst_ff <= 1'b0;
         trg_ld_ff <= 1'b0;
      end else begin
         dll_ff <= nxt_dll;
         dlm_ff <= nxt_dlm;
         ier_ff <= nxt_ier;
         fcr_ff <= nxt_fcr;
         lcr_ff <= nxt_lcr;
         mcr_ff <= nxt_mcr;
         spr_ff <= nxt_spr;
         enhanced_mode_select_ff <= nxt_enhanced_mode_select;
         feature_control_ff <= nxt_feature_control;
         efr_ff <= nxt_efr;
         trg_ff <= nxt_trg;
         thr_ff <= nxt_thr;
         rdata_ff <= nxt_rdata;
         thr_ld_ff <= nxt_thr_ld;
         pop_ff <= nxt_pop;
         lsr_rd_ff <= nxt_lsr_rd;
         msr_rd_ff <= nxt_msr_rd;
         rxrst_ff <= nxt_rxrst;
         txrst_ff <= nxt_txrst;
         trg_ld_ff <= nxt_trg_ld;
      end
   end

   // Outputs; shaded bits reach the datapath only while enabled.
   assign o_rd_data = rdata_ff;
   assign o_tx_holding = thr_ff;
   assign o_tx_holding_load = thr_ld_ff;
   assign o_rx_holding_pop = pop_ff;
   assign o_line_status_read = lsr_rd_ff;
   assign o_modem_status_read = msr_rd_ff;
   assign o_rx_fifo_reset = rxrst_ff;
   assign o_tx_fifo_reset = txrst_ff;
   assign o_trigger_load = trg_ld_ff;
   assign o_baud_divisor = {dlm_ff, dll_ff};
   assign o_interrupt_enable = ier_ff & shade_ier;
   assign o_fifo_control = fcr_ff & shade_fcr;
   assign o_line_control = lcr_ff;
   assign o_modem_control = mcr_ff & shade_mcr;
   assign o_scratch_pad = spr_ff;
   assign o_enhanced_mode_select = enhanced_mode_select_ff;
   assign o_feature_control = feature_control_ff;
   assign o_enhanced_function = efr_ff;
   assign o_fifo_trigger_level = trg_ff;
   assign o_data_terminal_ready = mcr_ff[URD_MCR_DTR];
   assign o_request_to_send = mcr_ff[URD_MCR_RTS];
   assign o_interrupt_output_enable = mcr_ff[URD_MCR_OUT2];
   assign o_loopback = mcr_ff[URD_MCR_LOOP];
   assign o_auto_cts_en = efr_ff[URD_EFR_AUTO_CTS];
   assign o_auto_rts_en = efr_ff[URD_EFR_AUTO_RTS];

   // Checks on decode, read data and side effects.
   sequence s_host_wr(logic [2:0] a);
      i_parallel_mode && i_wr && i_register_select_lines == a;
   endsequence

   property p_serial_blocks_host;
      @(posedge i_ref_clk) disable iff (i_rst)
      (!i_parallel_mode && i_wr && !i_mcu_wr) |=> $stable(lcr_ff) && $stable(dll_ff);
   endproperty
   a_serial_blocks_host: assert property (p_serial_blocks_host) else $error("host write in serial mode");

   property p_mcu_locked;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_parallel_mode && i_mcu_wr && !i_wr) |=> $stable(lcr_ff) && $stable(spr_ff);
   endproperty
   a_mcu_locked: assert property (p_mcu_locked) else $error("mcu write in parallel mode");

   property p_thr_load;
      @(posedge i_ref_clk) disable iff (i_rst)
      (s_host_wr(URD_A_HOLD) and (!dlab && !enh)) |=> o_tx_holding_load
         && o_tx_holding == $past(i_wr_data)
         ##1 (!o_tx_holding_load || $past(wr && addr == URD_A_HOLD));
   endproperty
   a_thr_load: assert property (p_thr_load) else $error("transmit load missing");

   property p_rev_code;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_parallel_mode && i_rd && i_register_select_lines == URD_A_HOLD && dlab && !enh
         && div_zero) |=> o_rd_data == P_REV_CODE;
   endproperty
   a_rev_code: assert property (p_rev_code) else $error("revision code not returned");

   property p_lcr_rw;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_host_wr(URD_A_LCR) ##1 (i_parallel_mode && i_rd && !i_wr
         && i_register_select_lines == URD_A_LCR) |=> o_rd_data == $past(i_wr_data, 2);
   endproperty
   a_lcr_rw: assert property (p_lcr_rw) else $error("line control readback");

   property p_dtr_pin;
      @(posedge i_ref_clk) disable iff (i_rst)
      (s_host_wr(URD_A_MCR) and !enh) |=> o_data_terminal_ready == $past(i_wr_data[0]);
   endproperty
   a_dtr_pin: assert property (p_dtr_pin) else $error("terminal ready pin wrong");

   property p_shade_zero;
      @(posedge i_ref_clk) disable iff (i_rst)
      !shade |-> (o_interrupt_enable & URD_IER_SHADE) == URD_ZERO
         && (o_modem_control & URD_MCR_SHADE) == URD_ZERO;
   endproperty
   a_shade_zero: assert property (p_shade_zero) else $error("shaded bit active");

   property p_reserved_read;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_parallel_mode && i_rd && enh && i_register_select_lines[2]) |=> o_rd_data == URD_ZERO;
   endproperty
   a_reserved_read: assert property (p_reserved_read) else $error("reserved read nonzero");

   property p_fifo_level_counter_no_effect;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_parallel_mode && i_rd && !i_wr && i_register_select_lines == URD_A_SPR && !enh
         && feature_control_ff[URD_FEATURE_CONTROL_SWAP]) |=> o_rd_data == $past(fifo_level) && $stable(spr_ff)
         && !o_rx_holding_pop;
   endproperty
   a_fifo_level_counter_no_effect: assert property (p_fifo_level_counter_no_effect) else $error("level read wrong");

   property p_auto_cts;
      @(posedge i_ref_clk) disable iff (i_rst)
      (s_host_wr(URD_A_ISR) and enh) |=> o_auto_cts_en == $past(i_wr_data[7]);
   endproperty
   a_auto_cts: assert property (p_auto_cts) else $error("auto cts enable wrong");

endmodule

//--- urd_regs_tb_top.sv
// Self-checking testbench of the UART register bank and address decoder.
`timescale 1ns/10ps
module urd_regs_tb_top;
   import urd_pkg::*;
   // Stimulus and observed signals.
   logic ref_clk = 1'b0;
   logic rst, par_mode, mcu_rd, mcu_wr, rd, wr, tx_load, rx_pop, lsr_rd, msr_rd;
   logic rx_frst, tx_frst, trg_load, dtr, rts, int_oe, loop, acts, arts;
   logic [2:0] sel, mcu_addr;
   logic [7:0] wdata, mcu_wdata, rd_data, rxh, isr_in, lsr_in, msr_in, rxl, txl, txh;
   logic [7:0] interrupt_enable, fifo_control, line_control, modem_control, scratch_pad, enhanced_mode_select, feature_control, enhanced_function, fifo_trigger_level, rv, pulses, pins;
   logic [15:0] baud;
   int bad_count = 0;
   int comparisons = 0;

   // Side-effect strobes and pins gathered so one compare also catches stray pulses.
   assign pulses = {1'b0, trg_load, tx_frst, rx_frst, msr_rd, lsr_rd, rx_pop, tx_load};
   assign pins = {2'b00, acts, arts, loop, int_oe, rts, dtr};

   // The clock toggles every 20 ns, a period of 40 ns.
   always #20 ref_clk = ~ref_clk;

   urd_host i_host (.i_ref_clk(ref_clk), .i_rd_data(rd_data), .o_register_select_lines(sel),
      .o_rd(rd), .o_wr(wr), .o_wr_data(wdata));

   urd_regs i_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_parallel_mode(par_mode),
      .i_register_select_lines(sel), .i_rd(rd), .i_wr(wr), .i_wr_data(wdata),
      .i_mcu_addr(mcu_addr), .i_mcu_rd(mcu_rd), .i_mcu_wr(mcu_wr), .i_mcu_wr_data(mcu_wdata),
      .o_rd_data(rd_data), .i_rx_holding(rxh), .i_interrupt_status(isr_in),
      .i_line_status(lsr_in), .i_modem_status(msr_in), .i_rx_fifo_level(rxl),
      .i_tx_fifo_level(txl), .o_tx_holding_load(tx_load), .o_tx_holding(txh),
      .o_rx_holding_pop(rx_pop), .o_line_status_read(lsr_rd), .o_modem_status_read(msr_rd),
      .o_rx_fifo_reset(rx_frst), .o_tx_fifo_reset(tx_frst), .o_trigger_load(trg_load),
      .o_baud_divisor(baud), .o_interrupt_enable(interrupt_enable), .o_fifo_control(fifo_control),
      .o_line_control(line_control), .o_modem_control(modem_control), .o_scratch_pad(scratch_pad),
      .o_enhanced_mode_select(enhanced_mode_select), .o_feature_control(feature_control), .o_enhanced_function(enhanced_function),
      .o_fifo_trigger_level(fifo_trigger_level), .o_data_terminal_ready(dtr), .o_request_to_send(rts),
      .o_interrupt_output_enable(int_oe), .o_loopback(loop), .o_auto_cts_en(acts),
      .o_auto_rts_en(arts));

   // Compares one byte and reports a mismatch at once.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Host write, then the strobes of that same cycle.
   task automatic w(input logic [2:0] a, input logic [7:0] d, input logic [7:0] pexp);
      i_host.access(a, 1'b1, d, rv);
      chk(pulses, pexp, "write strobes");
   endtask

   // Host read, then the returned byte and the strobes.
   task automatic r(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] pexp);
      i_host.access(a, 1'b0, 8'h00, rv);
      chk(rv, exp, "read data");
      chk(pulses, pexp, "read strobes");
   endtask

   // Microcontroller access at the next falling edge, held across one taking edge.
   task automatic mcu(input logic [2:0] a, input logic wr_en, input logic [7:0] d);
      @(negedge ref_clk);
      mcu_addr = a;
      mcu_wdata = d;
      mcu_wr = wr_en;
      mcu_rd = ~wr_en;
      @(posedge ref_clk);
      @(negedge ref_clk);
      mcu_wr = 1'b0;
      mcu_rd = 1'b0;
      mcu_addr = ~a;
      mcu_wdata = ~d;
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Cuts a hung run short and counts it as a mismatch.
   initial begin
      repeat (5000) @(posedge ref_clk);
      bad_count++;
      $display("mismatch at %0t: run did not finish", $time);
      stop_test;
   end

   // Main sequence of tests.
   initial begin
      rst = 1'b1;
      par_mode = 1'b1;
      mcu_addr = 3'h0;
      mcu_rd = 1'b0;
      mcu_wr = 1'b0;
      mcu_wdata = 8'h00;
      rxh = 8'h5C;
      isr_in = 8'h3F;
      lsr_in = 8'h61;
      msr_in = 8'hB4;
      rxl = 8'h11;
      txl = 8'h22;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      chk(line_control, 8'h00, "line control after reset");
      chk(pins, 8'h00, "pins after reset");
      $display("test reset done");
      // Standard set with divisor access off.
      w(URD_A_LCR, 8'h03, 8'h00);
      r(URD_A_LCR, 8'h03, 8'h00);
      i_host.write_read(URD_A_LCR, 8'h03, rv);
      chk(rv, 8'h03, "line control back to back");
      chk(pulses, 8'h00, "back to back strobes");
      r(URD_A_HOLD, 8'h5C, 8'h02);
      w(URD_A_HOLD, 8'hC3, 8'h01);
      chk(txh, 8'hC3, "transmit byte");
      w(URD_A_IER, 8'hFF, 8'h00);
      r(URD_A_IER, 8'h0F, 8'h00);
      r(URD_A_ISR, 8'h0F, 8'h00);
      w(URD_A_ISR, 8'h07, 8'h30);
      chk(fifo_control, 8'h01, "fifo control");
      r(URD_A_ISR, 8'hCF, 8'h00);
      w(URD_A_MCR, 8'hFF, 8'h00);
      r(URD_A_MCR, 8'h1B, 8'h00);
      chk(pins, 8'h0F, "modem pins");
      r(URD_A_LSR, 8'h61, 8'h04);
      r(URD_A_MSR, 8'hB4, 8'h08);
      w(URD_A_SPR, 8'hA5, 8'h00);
      r(URD_A_SPR, 8'hA5, 8'h00);
      $display("test standard set done");
      // Divisor bytes, with the codes shown while both are zero.
      w(URD_A_LCR, 8'h80, 8'h00);
      r(URD_A_HOLD, URD_REV_CODE, 8'h00);
      r(URD_A_IER, URD_ID_CODE, 8'h00);
      w(URD_A_HOLD, 8'h34, 8'h00);
      w(URD_A_IER, 8'h12, 8'h00);
      r(URD_A_HOLD, 8'h34, 8'h00);
      r(URD_A_IER, 8'h12, 8'h00);
      chk(baud[15:8], 8'h12, "divisor high");
      chk(baud[7:0], 8'h34, "divisor low");
      $display("test divisor done");
      // Enhanced set opened by the key value.
      w(URD_A_LCR, URD_ENH_KEY, 8'h00);
      w(URD_A_IER, 8'hFF, 8'h00);
      r(URD_A_IER, 8'hF3, 8'h00);
      w(URD_A_ISR, 8'hFF, 8'h00);
      r(URD_A_ISR, 8'hD0, 8'h00);
      chk(pins, 8'h3F, "flow control enables");
      chk(modem_control, 8'hFB, "shaded modem control");
      chk(interrupt_enable, 8'hCF, "shaded interrupt enable");
      w(URD_A_HOLD, 8'h2C, 8'h40);
      chk(fifo_trigger_level, 8'h2C, "trigger level");
      r(URD_A_HOLD, 8'h22, 8'h00);
      for (int a = 4; a < 8; a++) begin
         w(a[2:0], 8'h00, 8'h00);
         r(a[2:0], 8'h00, 8'h00);
      end
      chk(modem_control, 8'hFB, "modem control after reserved writes");
      chk(scratch_pad, 8'hA5, "scratch pad after reserved writes");
      $display("test enhanced set done");
      // Swapped place at address seven.
      w(URD_A_LCR, 8'h03, 8'h00);
      w(URD_A_SPR, 8'h71, 8'h00);
      chk(enhanced_mode_select, 8'h71, "mode select");
      chk(scratch_pad, 8'hA5, "scratch pad kept");
      r(URD_A_SPR, 8'h22, 8'h00);
      chk(enhanced_mode_select, 8'h71, "mode select after level read");
      $display("test swap done");
      // Ownership of the bank by host mode.
      par_mode = 1'b0;
      w(URD_A_LCR, 8'h55, 8'h00);
      chk(line_control, 8'h03, "host write in serial mode");
      mcu(URD_A_LCR, 1'b1, 8'h07);
      mcu(URD_A_LCR, 1'b0, 8'h00);
      chk(rd_data, 8'h07, "controller read");
      par_mode = 1'b1;
      mcu(URD_A_LCR, 1'b1, 8'h00);
      chk(line_control, 8'h07, "controller write in parallel mode");
      r(URD_A_LCR, 8'h07, 8'h00);
      $display("test ownership done");
      stop_test;
   end
endmodule
